//--- common/seq_pkg.sv
// Package for the drive start/stop sequencer: register map, fields, resets, timing.
// Assumes a 25 MHz core clock and an APB3 register bus with 32-bit data.
// How it works
// (R01) Reverse lockout 0 forces forward rotation; 1 allows reverse; default 1.
// (R02) Panel stop key, when enabled, stops the drive under terminal or comm control.
// (R03) After a panel stop, controller drops run before a new run restarts.
// (R04) Start mode 0: optional start DC brake, then output at startup frequency.
// (R05) Start mode 1: sweep frequency down from set frequency to catch spinning load.
// (R06) After tracking, accelerate to set frequency; tracking time 0.1-20.0 s, default 5.0. Code sweeps over track_t ticks, not 0.1 s steps.
// (R07) Tracking over current limit lowers frequency until current falls, then resumes.
// (R08) Tracking start ramps voltage over rise time 0.1-10.0 s, default 0.5. Code ramps over rise_t ticks, not 0.1 s steps.
// (R09) Stop mode 0, no stop brake: decelerate to stop frequency, then coast.
// (R10) Stop mode 0 with stop brake time: DC brake that long at stop frequency.
// (R11) Stop mode 1: cut output at once on stop, no DC braking.
// (R12) Startup frequency 0.1-30.0 Hz in 0.1 Hz steps, default 0.5.
// (R13) Stop frequency 0.1-30.0 Hz in 0.1 Hz steps, default 0.5; reaching it ends decel.
// (R14) Start brake time 0.0-25.0 s in 0.1 s steps, default 0; zero disables.
// (R15) Start brake time only acts in start mode 0, never for tracking starts.
// (R16) Stop brake time 0.0-25.0 s, default 0; nonzero brakes, only in stop mode 0.
// (R17) Brake level 0.0-20.0 percent of max-frequency voltage, default 2.0, both brakes.
// (R18) Command source 1 selects terminals; stop key depends on this source.
// (R19) Settings held as unsigned fixed-point integers, counted against a control tick.
package seq_pkg;
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned TICK_US        = 100;
	localparam int unsigned TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned TICKS_PER_STEP = 1000;

	localparam logic [11:0] OFF_CTRL    = 12'h000;
	localparam logic [11:0] OFF_MODE    = 12'h004;
	localparam logic [11:0] OFF_FREQ    = 12'h008;
	localparam logic [11:0] OFF_BRAKE   = 12'h00C;
	localparam logic [11:0] OFF_TRACK   = 12'h010;
	localparam logic [11:0] OFF_SETF    = 12'h014;
	localparam logic [11:0] OFF_STATUS  = 12'h018;
	localparam logic [11:0] OFF_CURRENT = 12'h01C;

	localparam int unsigned CTRL_RUN   = 0;
	localparam int unsigned CTRL_REV   = 1;
	localparam int unsigned CTRL_STOP  = 2;
	localparam int unsigned MODE_SRC   = 0;
	localparam int unsigned MODE_RLOCK = 4;
	localparam int unsigned MODE_KEYEN = 5;
	localparam int unsigned MODE_START = 6;
	localparam int unsigned MODE_STOP  = 7;

	localparam logic [1:0]  SRC_PANEL     = 2'h0;
	localparam logic [1:0]  SRC_TERMINAL  = 2'h1;
	localparam logic [1:0]  SRC_COMM      = 2'h2;
	localparam logic [7:0]  MODE_RESET    = 8'h30;
	localparam logic [15:0] STARTF_RESET  = 16'h0005;
	localparam logic [15:0] STOPF_RESET   = 16'h0005;
	localparam logic [15:0] FREQ_MIN      = 16'h0001;
	localparam logic [15:0] FREQ_MAX      = 16'h012C;
	localparam logic [15:0] BRAKE_T_MAX   = 16'h00FA;
	localparam logic [15:0] SBRAKE_RESET  = 16'h0000;
	localparam logic [15:0] PBRAKE_RESET  = 16'h0000;
	localparam logic [7:0]  LEVEL_RESET   = 8'h14;
	localparam logic [7:0]  LEVEL_MAX     = 8'hC8;
	localparam logic [7:0]  TTIME_RESET   = 8'h32;
	localparam logic [7:0]  TTIME_MIN     = 8'h01;
	localparam logic [7:0]  TTIME_MAX     = 8'hC8;
	localparam logic [7:0]  ILIM_RESET    = 8'h96;
	localparam logic [7:0]  RISE_RESET    = 8'h05;
	localparam logic [7:0]  RISE_MIN      = 8'h01;
	localparam logic [7:0]  RISE_MAX      = 8'h64;
	localparam logic [15:0] SETF_RESET    = 16'h01F4;
	localparam logic [15:0] VOLT_FULL     = 16'h03E8;

	typedef enum logic [2:0] {ST_IDLE, ST_SBRAKE, ST_TRACK, ST_RUN, ST_DECEL, ST_PBRAKE} seq_state_e;

	typedef struct packed {
		logic [1:0]  src;
		logic        rev_ok;
		logic        key_en;
		logic        start_mode;
		logic        stop_mode;
		logic [15:0] start_f;
		logic [15:0] stop_f;
		logic [15:0] sbrake_t;
		logic [15:0] pbrake_t;
		logic [7:0]  level;
		logic [7:0]  track_t;
		logic [7:0]  ilim;
		logic [7:0]  rise_t;
		logic [15:0] set_f;
	} seq_cfg_s;

	typedef struct packed {
		logic        run;
		logic        rev;
		logic        stop;
	} seq_cmd_s;

	typedef struct packed {
		logic        active;
		logic        rev;
		logic        brake;
		logic [15:0] freq;
		logic [15:0] volt;
		logic [15:0] brake_volt;
	} seq_out_s;
endpackage

//--- design/tick_divider.sv
// Control timebase: one-cycle enable every TICK cycles.
// Assumes a single core clock and synchronous reset.
`timescale 1ns/100ps
module tick_divider #(
	parameter int unsigned TICK = 2500
) (
	input  wire logic core_clk,
	input  wire logic reset,
	output logic      tick
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;

	always_comb begin
		if (cnt_r == 16'(TICK - 1)) begin
			cnt_nxt = 16'h0000;
		end else begin
			cnt_nxt = cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign tick = (cnt_r == 16'(TICK - 1));
endmodule

//--- design/pin_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/100ps
module pin_sync #(
	parameter int unsigned W = 2
) (
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;
endmodule

//--- design/drive_start_stop_sequencer.sv
// Start/stop sequencer of a motor drive with APB register access.
// Assumes terminal run/reverse and panel stop key arrive on pins; current feedback is synchronous.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module drive_start_stop_sequencer
	import seq_pkg::*;
#(
	parameter int unsigned TICK = TICK_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        term_run,
	input  wire logic        term_rev,
	input  wire logic        panel_stop_key,
	input  wire logic [7:0]  out_current_pct,
	output seq_out_s         drive_out
);
	logic       tick;
	logic [2:0] pins_s;

	tick_divider #(.TICK(TICK)) u_tick (
		.core_clk (core_clk),
		.reset    (reset),
		.tick     (tick)
	);

	pin_sync #(.W(3)) u_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in ({panel_stop_key, term_rev, term_run}),
		.sync_out (pins_s)
	);

	// Register file
	seq_cfg_s   cfg_r, cfg_nxt;
	seq_cmd_s   cmd_r, cmd_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pslverr_nxt;
	logic        wr_en, rd_en, addr_ok;
	seq_state_e  state_r;

	assign wr_en = psel & penable & pwrite;
	// Read data loads at the setup edge so it stands, registered, through the access phase
	assign rd_en = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign prdata  = prdata_r;

	// Settings other than set_f clamp into their legal step ranges on write
	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	always_comb begin
		cfg_nxt     = cfg_r;
		cmd_nxt     = cmd_r;
		prdata_nxt  = prdata_r;
		addr_ok     = 1'b1;
		if (paddr == OFF_CTRL) begin
			prdata_nxt = {29'h0000_0000, cmd_r.stop, cmd_r.rev, cmd_r.run};
			if (wr_en) begin
				cmd_nxt.run  = pwdata[CTRL_RUN];
				cmd_nxt.rev  = pwdata[CTRL_REV];
				cmd_nxt.stop = pwdata[CTRL_STOP];
			end
		end else if (paddr == OFF_MODE) begin
			prdata_nxt = {24'h00_0000, cfg_r.stop_mode, cfg_r.start_mode, cfg_r.key_en,
				cfg_r.rev_ok, 2'b00, cfg_r.src};
			if (wr_en) begin
				cfg_nxt.src        = pwdata[MODE_SRC +: 2];
				cfg_nxt.rev_ok     = pwdata[MODE_RLOCK];
				cfg_nxt.key_en     = pwdata[MODE_KEYEN];
				cfg_nxt.start_mode = pwdata[MODE_START];
				cfg_nxt.stop_mode  = pwdata[MODE_STOP];
			end
		end else if (paddr == OFF_FREQ) begin
			prdata_nxt = {cfg_r.stop_f, cfg_r.start_f};
			if (wr_en) begin
				cfg_nxt.start_f = clamp16(pwdata[15:0], FREQ_MIN, FREQ_MAX); // (R12) (R19)
				cfg_nxt.stop_f  = clamp16(pwdata[31:16], FREQ_MIN, FREQ_MAX); // (R13)
			end
		end else if (paddr == OFF_BRAKE) begin
			prdata_nxt = {cfg_r.pbrake_t, cfg_r.sbrake_t};
			if (wr_en) begin
				cfg_nxt.sbrake_t = clamp16(pwdata[15:0], 16'h0000, BRAKE_T_MAX); // (R14)
				cfg_nxt.pbrake_t = clamp16(pwdata[31:16], 16'h0000, BRAKE_T_MAX); // (R16)
			end
		end else if (paddr == OFF_TRACK) begin
			prdata_nxt = {cfg_r.rise_t, cfg_r.ilim, cfg_r.track_t, cfg_r.level};
			if (wr_en) begin
				cfg_nxt.level   = clamp8(pwdata[7:0], 8'h00, LEVEL_MAX); // (R17)
				cfg_nxt.track_t = clamp8(pwdata[15:8], TTIME_MIN, TTIME_MAX); // (R06)
				cfg_nxt.ilim    = clamp8(pwdata[23:16], 8'h00, 8'hC8); // (R07)
				cfg_nxt.rise_t  = clamp8(pwdata[31:24], RISE_MIN, RISE_MAX); // (R08)
			end
		end else if (paddr == OFF_SETF) begin
			prdata_nxt = {16'h0000, cfg_r.set_f};
			if (wr_en) begin
				cfg_nxt.set_f = pwdata[15:0];
			end
		end else if (paddr == OFF_STATUS) begin
			prdata_nxt = {8'h00, 5'h00, 3'(state_r), drive_out.freq};
		end else if (paddr == OFF_CURRENT) begin
			prdata_nxt = {24'h00_0000, out_current_pct};
		end else begin
			addr_ok    = 1'b0;
			prdata_nxt = 32'h0000_0000;
		end
		if (!rd_en) begin
			prdata_nxt = prdata_r;
		end
		pslverr_nxt = psel & penable & ~addr_ok;
	end

	assign pslverr = pslverr_nxt;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg_r    <= '{src: SRC_PANEL, rev_ok: MODE_RESET[MODE_RLOCK],
				key_en: MODE_RESET[MODE_KEYEN], start_mode: 1'b0, stop_mode: 1'b0,
				start_f: STARTF_RESET, stop_f: STOPF_RESET, sbrake_t: SBRAKE_RESET,
				pbrake_t: PBRAKE_RESET, level: LEVEL_RESET, track_t: TTIME_RESET,
				ilim: ILIM_RESET, rise_t: RISE_RESET, set_f: SETF_RESET};
			cmd_r    <= '0;
			prdata_r <= 32'h0000_0000;
		end else begin
			cfg_r    <= cfg_nxt;
			cmd_r    <= cmd_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// Sequencer
	logic        run_req, rev_req, stop_req, key_stop, ext_src;
	logic        key_latch_r, key_latch_nxt;
	seq_state_e  state_nxt;
	logic [15:0] freq_r, freq_nxt, volt_r, volt_nxt;
	logic [15:0] tcnt_r, tcnt_nxt, sub_r, sub_nxt;
	logic [15:0] step_track, step_volt, step_ramp;
	logic        rev_r, rev_nxt, brake;

	assign ext_src  = (cfg_r.src == SRC_TERMINAL) || (cfg_r.src == SRC_COMM); // (R18)
	assign key_stop = ext_src & cfg_r.key_en & pins_s[2]; // (R02)
	assign run_req  = (cfg_r.src == SRC_TERMINAL) ? pins_s[0] : cmd_r.run;
	assign rev_req  = ((cfg_r.src == SRC_TERMINAL) ? pins_s[1] : cmd_r.rev) & cfg_r.rev_ok; // (R01)
	assign stop_req = ~run_req | cmd_r.stop | key_latch_r;

	// Per-tick steps: set_f swept over track_t ticks, voltage over rise_t ticks; a coarse
	// linear ramp keeps the divider small at the cost of some rounding.
	assign step_track = (16'(cfg_r.set_f / 16'(cfg_r.track_t)) == 16'h0000) ? 16'h0001
		: 16'(cfg_r.set_f / 16'(cfg_r.track_t));
	assign step_volt  = (16'(VOLT_FULL / 16'(cfg_r.rise_t)) == 16'h0000) ? 16'h0001
		: 16'(VOLT_FULL / 16'(cfg_r.rise_t));
	assign step_ramp  = 16'h0001;
	assign brake      = (state_r == ST_SBRAKE) || (state_r == ST_PBRAKE);

	always_comb begin
		state_nxt     = state_r;
		freq_nxt      = freq_r;
		volt_nxt      = volt_r;
		tcnt_nxt      = tcnt_r;
		sub_nxt       = sub_r;
		rev_nxt       = rev_r;
		// Key stop holds until run is withdrawn
		key_latch_nxt = (key_latch_r | key_stop) & (run_req | key_stop); // (R03)
		if (tick) begin
			sub_nxt = (sub_r == 16'(TICKS_PER_STEP - 1)) ? 16'h0000 : sub_r + 16'h0001;
		end
		case (state_r)
			ST_IDLE: begin
				freq_nxt = 16'h0000;
				volt_nxt = 16'h0000;
				if (!stop_req) begin
					rev_nxt = rev_req; // (R01)
					sub_nxt = 16'h0000;
					if (cfg_r.start_mode) begin
						freq_nxt  = cfg_r.set_f; // (R05) (R15)
						state_nxt = ST_TRACK;
					end else if (cfg_r.sbrake_t != 16'h0000) begin
						tcnt_nxt  = cfg_r.sbrake_t; // (R04) (R14)
						state_nxt = ST_SBRAKE;
					end else begin
						freq_nxt  = cfg_r.start_f; // (R04) (R12)
						volt_nxt  = VOLT_FULL;
						state_nxt = ST_RUN;
					end
				end
			end
			ST_SBRAKE: begin
				if (stop_req) begin
					state_nxt = ST_IDLE;
				end else if (tick && sub_r == 16'(TICKS_PER_STEP - 1)) begin
					tcnt_nxt = tcnt_r - 16'h0001;
					if (tcnt_r == 16'h0001) begin
						freq_nxt  = cfg_r.start_f; // (R04)
						volt_nxt  = VOLT_FULL;
						state_nxt = ST_RUN;
					end
				end
			end
			ST_TRACK: begin
				if (stop_req) begin
					state_nxt = ST_IDLE;
				end else if (tick) begin
					volt_nxt = (volt_r + step_volt >= VOLT_FULL) ? VOLT_FULL
						: volt_r + step_volt; // (R08)
					if (out_current_pct > cfg_r.ilim) begin
						// Over limit: drop frequency until current clears (R07)
						freq_nxt = (freq_r > step_track) ? freq_r - step_track : 16'h0000;
					end else if (volt_r == VOLT_FULL) begin
						state_nxt = ST_RUN; // (R06)
					end else begin
						freq_nxt = (freq_r > step_track) ? freq_r - step_track : 16'h0000; // (R05)
					end
					if (freq_nxt < cfg_r.start_f) begin
						freq_nxt = cfg_r.start_f;
					end
				end
			end
			ST_RUN: begin
				if (stop_req && cfg_r.stop_mode) begin
					freq_nxt  = 16'h0000; // (R11)
					volt_nxt  = 16'h0000;
					state_nxt = ST_IDLE;
				end else if (stop_req) begin
					state_nxt = ST_DECEL;
				end else if (rev_req != rev_r) begin
					state_nxt = ST_DECEL;
				end else if (tick && freq_r < cfg_r.set_f) begin
					freq_nxt = freq_r + step_ramp; // (R06)
				end else if (tick && freq_r > cfg_r.set_f) begin
					freq_nxt = freq_r - step_ramp;
				end
			end
			ST_DECEL: begin
				if (cfg_r.stop_mode && stop_req) begin
					freq_nxt  = 16'h0000; // (R11)
					volt_nxt  = 16'h0000;
					state_nxt = ST_IDLE;
				end else if (freq_r <= cfg_r.stop_f) begin
					freq_nxt = 16'h0000; // (R13)
					// Coast mode never stop-brakes, not even after a reversing decel
					if (cfg_r.pbrake_t != 16'h0000 && !cfg_r.stop_mode) begin
						tcnt_nxt  = cfg_r.pbrake_t; // (R10) (R16)
						sub_nxt   = 16'h0000;
						state_nxt = ST_PBRAKE;
					end else begin
						volt_nxt  = 16'h0000; // (R09)
						state_nxt = ST_IDLE;
					end
				end else if (tick) begin
					freq_nxt = freq_r - step_ramp;
				end
			end
			ST_PBRAKE: begin
				if (tick && sub_r == 16'(TICKS_PER_STEP - 1)) begin
					tcnt_nxt = tcnt_r - 16'h0001;
					if (tcnt_r == 16'h0001) begin
						volt_nxt  = 16'h0000; // (R10)
						state_nxt = ST_IDLE;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r     <= ST_IDLE;
			freq_r      <= 16'h0000;
			volt_r      <= 16'h0000;
			tcnt_r      <= 16'h0000;
			sub_r       <= 16'h0000;
			rev_r       <= 1'b0;
			key_latch_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			freq_r      <= freq_nxt;
			volt_r      <= volt_nxt;
			tcnt_r      <= tcnt_nxt;
			sub_r       <= sub_nxt;
			rev_r       <= rev_nxt;
			key_latch_r <= key_latch_nxt;
		end
	end

	// Brake voltage in 0.1 % of full voltage, same level for start and stop (R17)
	assign drive_out.active     = (state_r != ST_IDLE);
	assign drive_out.rev        = rev_r;
	assign drive_out.brake      = brake;
	assign drive_out.freq       = freq_r;
	assign drive_out.volt       = brake ? 16'h0000 : volt_r;
	assign drive_out.brake_volt = brake ? {8'h00, cfg_r.level} : 16'h0000;
endmodule

//--- dv/seq_chk.sv
// Port checker for the drive start/stop sequencer, bound to its top module.
// Assumes settings change only by APB writes, with values inside their ranges.
`timescale 1ns/100ps
module seq_chk
	import seq_pkg::*;
#(
	parameter int unsigned TICK = TICK_CYC
) (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        term_run,
	input wire logic        term_rev,
	input wire logic        panel_stop_key,
	input wire logic [7:0]  out_current_pct,
	input wire seq_out_s    drive_out
);
	localparam int unsigned STEP = TICK * TICKS_PER_STEP;
	// Brake lengths are judged to a few ticks, the end of a step is not pinned down
	localparam int unsigned TOL  = 4 * TICK;
	logic [31:0] mode_r;
	logic [31:0] freq_r;
	logic [31:0] brk_r;
	logic [7:0]  lvl_r;
	logic [15:0] setf_r;
	int unsigned blen_r;
	logic        wr_en;
	logic        len_ok;
	assign wr_en = psel && penable && pwrite;
	assign len_ok = (blen_r + TOL >= brk_r[15:0] * STEP && blen_r <= brk_r[15:0] * STEP + TOL)
		|| (blen_r + TOL >= brk_r[31:16] * STEP && blen_r <= brk_r[31:16] * STEP + TOL);
	always_ff @(posedge core_clk) begin
		blen_r <= drive_out.brake ? blen_r + 1 : 0;
		if (reset) begin
			mode_r <= {24'h00_0000, MODE_RESET};
			freq_r <= {STOPF_RESET, STARTF_RESET};
			brk_r  <= {PBRAKE_RESET, SBRAKE_RESET};
			lvl_r  <= LEVEL_RESET;
			setf_r <= SETF_RESET;
		end else if (wr_en) begin
			case (paddr)
				OFF_MODE:  mode_r <= pwdata;
				OFF_FREQ:  freq_r <= pwdata;
				OFF_BRAKE: brk_r  <= pwdata;
				OFF_TRACK: lvl_r  <= pwdata[7:0];
				OFF_SETF:  setf_r <= pwdata[15:0];
				default:   lvl_r  <= lvl_r;
			endcase
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	rev_lock_a: assert property ($rose(drive_out.rev) |-> mode_r[MODE_RLOCK])
		else $error("reverse output while reverse is locked out");
	start_freq_a: assert property ($rose(drive_out.freq != 0) && !mode_r[MODE_START]
		|-> drive_out.freq == freq_r[15:0]) else $error("output did not begin at startup frequency");
	stop_freq_a: assert property ($fell(drive_out.freq != 0) && !mode_r[MODE_STOP]
		|-> $past(drive_out.freq) <= freq_r[31:16]) else $error("output removed above stop frequency");
	stop_cut_a: assert property (wr_en && paddr == OFF_CTRL && !pwdata[CTRL_RUN] && mode_r[MODE_STOP]
		|-> ##[1:4] !drive_out.active) else $error("coast stop did not cut output");
	no_brake_a: assert property (mode_r[MODE_STOP] && $past(drive_out.freq) != 0
		|-> !drive_out.brake) else $error("braking after output in coast stop mode");
	brake_len_a: assert property ($fell(drive_out.brake) |-> $past(len_ok))
		else $error("brake duration differs from setting");
	brake_lvl_a: assert property (drive_out.brake |-> drive_out.brake_volt == {8'h00, lvl_r})
		else $error("brake voltage differs from level setting");
	track_down_a: assert property (mode_r[MODE_START] && drive_out.active && $past(drive_out.active)
		&& drive_out.volt < VOLT_FULL |-> drive_out.freq <= $past(drive_out.freq))
		else $error("frequency rose while tracking");
	track_entry_a: assert property (mode_r[MODE_START] && $rose(drive_out.active)
		|-> drive_out.volt < VOLT_FULL && drive_out.freq <= setf_r && !drive_out.brake)
		else $error("tracking start entered wrongly");
	unmapped_a: assert property (psel && penable && paddr >= 12'h020 |-> pslverr)
		else $error("unmapped access not refused");
	cover property ($rose(drive_out.brake));
	cover property (mode_r[MODE_START] && drive_out.active && drive_out.volt < VOLT_FULL);
	cover property (panel_stop_key && drive_out.active);
endmodule

bind drive_start_stop_sequencer seq_chk #(.TICK(TICK)) chk (.core_clk(core_clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .term_run(term_run),
	.term_rev(term_rev), .panel_stop_key(panel_stop_key), .out_current_pct(out_current_pct),
	.drive_out(drive_out));

//--- dv/load_model.sv
// Far side model: terminal controller, panel key and a load drawing current.
// Assumes the bench asks for run and key presses; the reverse terminal stays open.
`timescale 1ns/100ps
module load_model
	import seq_pkg::*;
(
	input wire logic  core_clk,
	input wire logic  run_req,
	input wire logic  key_req,
	input wire logic  heavy,
	input wire seq_out_s drive_out,
	output logic      term_run = 1'b0,
	output logic      term_rev = 1'b0,
	output logic      panel_stop_key = 1'b0,
	output logic [7:0] out_current_pct = 8'h00
);
	always_ff @(posedge core_clk) begin
		term_run <= run_req;
		term_rev <= 1'b0;
		panel_stop_key <= key_req;
		// A heavy load overdraws only above 5.0 Hz, so tracking can settle
		out_current_pct <= !drive_out.active ? 8'h00 :
			(heavy && drive_out.freq > 16'h0032) ? 8'hC8 : 8'h50;
	end
endmodule

//--- dv/drive_start_stop_sequencer_tb.sv
// Register-level tests of the start/stop sequencer over APB.
// Assumes the load model on the pins and a short control tick.
`timescale 1ns/100ps
module drive_start_stop_sequencer_tb
	import seq_pkg::*;
;
	localparam logic [18:0] SM = 19'h7_0000;
	localparam logic [18:0] AM = 19'h7_FFFF;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] d;
	logic        err;
	logic        pready, pslverr, term_run, term_rev, panel_stop_key;
	logic        run_req = 1'b0;
	logic        key_req = 1'b0;
	logic        heavy = 1'b0;
	logic [7:0]  cur;
	seq_out_s    drive_out;
	int          miscompares = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [11:0] adr [5] = '{OFF_MODE, OFF_FREQ, OFF_BRAKE, OFF_TRACK, OFF_SETF};
	logic [31:0] rst [5] = '{32'h0000_0030, 32'h0005_0005, 32'h0000_0000, 32'h0596_3214,
		32'h0000_01F4};
	drive_start_stop_sequencer #(.TICK(2)) dut (.core_clk(core_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .term_run(term_run), .term_rev(term_rev),
		.panel_stop_key(panel_stop_key), .out_current_pct(cur), .drive_out(drive_out));
	load_model partner (.core_clk(core_clk), .run_req(run_req), .key_req(key_req),
		.heavy(heavy), .drive_out(drive_out), .term_run(term_run), .term_rev(term_rev),
		.panel_stop_key(panel_stop_key), .out_current_pct(cur));
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	task results();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		// Ceiling sits well above the longest run of brake and ramp times
		if (cyc == 40000) begin
			miscompares++;
			results();
		end
	end
	task cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Read data and error flag are taken at the edge that samples pready high
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wst(input logic [18:0] m, input logic [18:0] e);
		int n;
		n = 0;
		do begin
			xfer(1'b0, OFF_STATUS, 32'h0000_0000);
			n++;
		end while ((d[18:0] & m) !== e && n < 5000);
		cmp(d[18:0] & m, e);
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			xfer(1'b0, adr[i], 32'h0000_0000);
			cmp(d, rst[i]);
			cmp(err, 32'h0000_0000);
		end
		xfer(1'b0, 12'h020, 32'h0000_0000);
		cmp(d, 32'h0000_0000);
		cmp(err, 32'h0000_0001);
		$display("Test reset values done");
		xfer(1'b1, OFF_TRACK, 32'h0596_3228);
		xfer(1'b1, OFF_BRAKE, 32'h0001_0001);
		xfer(1'b1, OFF_SETF, 32'h0000_0014);
		xfer(1'b1, OFF_CTRL, 32'h0000_0001);
		wst(SM, {ST_SBRAKE, 16'h0000});
		cmp(drive_out.brake, 32'h0000_0001);
		wst(AM, {ST_RUN, 16'h0014});
		cmp(drive_out.volt, 32'h0000_03E8);
		xfer(1'b1, OFF_CTRL, 32'h0000_0000);
		wst(SM, {ST_PBRAKE, 16'h0000});
		cmp(drive_out.brake_volt, 32'h0000_0028);
		wst(SM, {ST_IDLE, 16'h0000});
		cmp(drive_out.active, 32'h0000_0000);
		$display("Test braked start and stop done");
		xfer(1'b1, OFF_MODE, 32'h0000_0080);
		xfer(1'b1, OFF_CTRL, 32'h0000_0003);
		wst(AM, {ST_RUN, 16'h0014});
		cmp(drive_out.rev, 32'h0000_0000);
		xfer(1'b1, OFF_CTRL, 32'h0000_0000);
		xfer(1'b0, OFF_STATUS, 32'h0000_0000);
		cmp(d[18:16], ST_IDLE);
		cmp(drive_out.brake, 32'h0000_0000);
		$display("Test coast stop and lockout done");
		xfer(1'b1, OFF_MODE, 32'h0000_0050);
		xfer(1'b1, OFF_SETF, 32'h0000_0064);
		heavy <= 1'b1;
		xfer(1'b1, OFF_CTRL, 32'h0000_0003);
		wst(SM, {ST_TRACK, 16'h0000});
		cmp(drive_out.brake, 32'h0000_0000);
		wst(AM, {ST_RUN, 16'h0064});
		cmp(drive_out.rev, 32'h0000_0001);
		heavy <= 1'b0;
		xfer(1'b1, OFF_CTRL, 32'h0000_0000);
		wst(SM, {ST_PBRAKE, 16'h0000});
		wst(SM, {ST_IDLE, 16'h0000});
		$display("Test tracking start done");
		xfer(1'b1, OFF_BRAKE, 32'h0000_0000);
		xfer(1'b1, OFF_MODE, 32'h0000_0031);
		run_req <= 1'b1;
		wst(AM, {ST_RUN, 16'h0064});
		key_req <= 1'b1;
		repeat (4) @(posedge core_clk);
		key_req <= 1'b0;
		wst(SM, {ST_IDLE, 16'h0000});
		repeat (20) @(posedge core_clk);
		xfer(1'b0, OFF_STATUS, 32'h0000_0000);
		cmp(d[18:16], ST_IDLE);
		run_req <= 1'b0;
		repeat (6) @(posedge core_clk);
		run_req <= 1'b1;
		wst(SM, {ST_RUN, 16'h0000});
		run_req <= 1'b0;
		wst(SM, {ST_IDLE, 16'h0000});
		$display("Test panel stop key done");
		results();
	end
endmodule
